// >>> design/dcc_channel_ctrl.v
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Function
// - The normal-completion interrupt is raised only while its enable bit is 1.
// - The normal-completion interrupt enable at bit 23 resets to 1.
// - The abnormal-completion enable at bit 22 resets to 1 and gates abnormal-completion interrupts.
// - Reserved bit 21 resets to 1 though software always writes 0 to it.
// - The endian select at bit 17 resets to 1, meaning big-endian.
// - Endian select 0 means little-endian, and software programs it to 0.
// - The request source at bit 14 resets to 0; 1 selects external requests, 0 software starts.
// - The request polarity at bit 13 resets to 0 and matters only for external requests.
// - The level-mode field at bit 12 resets to 0.
module dcc_channel_ctrl (
	input  wire        CLK,
	input  wire        RESET,
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output reg         S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output reg         S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output reg         S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	input  wire        CHANNEL_REQUEST_LINE,
	input  wire        NORMAL_DONE,
	input  wire        ABNORMAL_DONE,
	output reg         NORMAL_DONE_IRQ,
	output reg         ABNORMAL_DONE_IRQ,
	output reg         BIG_ENDIAN,
	output reg         TRANSFER_REQUEST,
	output reg         IRQ
);

	reg  [31:0]               ctrl_reg;
	reg  [`DCC_ST_WIDTH-1:0]  status_reg;
	reg  [`DCC_ST_WIDTH-1:0]  status_next;
	reg  [`DCC_ST_WIDTH-1:0]  mask_reg;
	reg  [7:0]                awaddr_reg;
	reg  [31:0]               wdata_reg;
	reg  [3:0]                wstrb_reg;
	reg                       aw_have_reg;
	reg                       w_have_reg;
	reg  [31:0]               rdata_next;
	reg  [1:0]                rresp_next;
	wire                      normal_event;
	wire                      abnormal_event;
	wire                      req_active;
	wire                      req_pulse;
	wire                      do_write;
	wire                      do_read;
	wire                      status_read;
	wire [7:0]                wr_addr;
	wire [31:0]               wr_data;
	wire [3:0]                wr_strb;

	// Merge write data under byte strobes
	function [31:0] strobe_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer i;
		begin
			strobe_merge = old_val;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					strobe_merge[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	function addr_known;
		input [7:0] a;
		begin
			addr_known = (a == `DCC_ADDR_CTRL) || (a == `DCC_ADDR_STATUS) ||
				(a == `DCC_ADDR_MASK) || (a == `DCC_ADDR_EVENT);
		end
	endfunction

	dcc_irq_gate u_irq_gate (
		.clk             (CLK),
		.reset           (RESET),
		.normal_enable   (ctrl_reg[`DCC_BIT_NIE]),
		.abnormal_enable (ctrl_reg[`DCC_BIT_AIE]),
		.normal_done     (NORMAL_DONE),
		.abnormal_done   (ABNORMAL_DONE),
		.normal_event    (normal_event),
		.abnormal_event  (abnormal_event)
	);

	dcc_req_qual u_req_qual (
		.clk        (CLK),
		.reset      (RESET),
		.source_ext (ctrl_reg[`DCC_BIT_EXR]),
		.polarity   (ctrl_reg[`DCC_BIT_POL]),
		.level_mode (ctrl_reg[`DCC_BIT_LEV]),
		.line_in    (CHANNEL_REQUEST_LINE),
		.req_active (req_active),
		.req_pulse  (req_pulse)
	);

	// Address and data may arrive in either order
	assign wr_addr  = aw_have_reg ? awaddr_reg : S_AXI_AWADDR;
	assign wr_data  = w_have_reg ? wdata_reg : S_AXI_WDATA;
	assign wr_strb  = w_have_reg ? wstrb_reg : S_AXI_WSTRB;
	assign do_write = (aw_have_reg | (S_AXI_AWVALID & S_AXI_AWREADY)) &
		(w_have_reg | (S_AXI_WVALID & S_AXI_WREADY)) & ~S_AXI_BVALID;
	assign do_read  = S_AXI_ARVALID & S_AXI_ARREADY;
	assign status_read = do_read & (S_AXI_ARADDR == `DCC_ADDR_STATUS);

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `DCC_RESP_OKAY;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			awaddr_reg    <= 8'h00;
			wdata_reg     <= 32'h00000000;
			wstrb_reg     <= 4'h0;
		end else begin
			S_AXI_AWREADY <= ~aw_have_reg & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID & ~do_write;
			S_AXI_WREADY  <= ~w_have_reg & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID & ~do_write;
			if (do_write) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= addr_known(wr_addr) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
			end else begin
				if (S_AXI_AWVALID & S_AXI_AWREADY) begin
					aw_have_reg <= 1'b1;
					awaddr_reg  <= S_AXI_AWADDR;
				end
				if (S_AXI_WVALID & S_AXI_WREADY) begin
					w_have_reg <= 1'b1;
					wdata_reg  <= S_AXI_WDATA;
					wstrb_reg  <= S_AXI_WSTRB;
				end
				if (S_AXI_BVALID & S_AXI_BREADY)
					S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Control and mask registers
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_reg <= `DCC_CTRL_RESET;
			mask_reg <= `DCC_MASK_RESET;
		end else if (do_write) begin
			// Reserved bits hold what software writes; software keeps them 0
			if (wr_addr == `DCC_ADDR_CTRL)
				ctrl_reg <= strobe_merge(ctrl_reg, wr_data, wr_strb) & `DCC_CTRL_MASK;
			// Mask bits all sit in byte lane 0
			if ((wr_addr == `DCC_ADDR_MASK) && wr_strb[0])
				mask_reg <= wr_data[`DCC_ST_WIDTH-1:0];
		end
	end

	// Sticky status: a new event wins over the clear of a status read
	always @* begin
		status_next = status_reg;
		if (status_read)
			status_next = {`DCC_ST_WIDTH{1'b0}};
		if (normal_event)
			status_next[`DCC_ST_NORMAL] = 1'b1;
		if (abnormal_event)
			status_next[`DCC_ST_ABNORMAL] = 1'b1;
		if (req_pulse)
			status_next[`DCC_ST_REQUEST] = 1'b1;
	end

	always @* begin
		rresp_next = `DCC_RESP_OKAY;
		case (S_AXI_ARADDR)
			`DCC_ADDR_CTRL:   rdata_next = ctrl_reg;
			`DCC_ADDR_STATUS: rdata_next = {29'h0, status_reg};
			`DCC_ADDR_MASK:   rdata_next = {29'h0, mask_reg};
			`DCC_ADDR_EVENT:  rdata_next = {29'h0, req_active, ABNORMAL_DONE, NORMAL_DONE};
			default: begin
				rdata_next = 32'h00000000;
				rresp_next = `DCC_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h00000000;
			S_AXI_RRESP   <= `DCC_RESP_OKAY;
			status_reg    <= {`DCC_ST_WIDTH{1'b0}};
		end else begin
			status_reg    <= status_next;
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~do_read;
			if (do_read) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rdata_next;
				S_AXI_RRESP  <= rresp_next;
			end else if (S_AXI_RVALID & S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// Outputs straight from flip-flops
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			NORMAL_DONE_IRQ   <= 1'b0;
			ABNORMAL_DONE_IRQ <= 1'b0;
			BIG_ENDIAN        <= 1'b1;
			TRANSFER_REQUEST  <= 1'b0;
			IRQ               <= 1'b0;
		end else begin
			NORMAL_DONE_IRQ   <= normal_event;
			ABNORMAL_DONE_IRQ <= abnormal_event;
			BIG_ENDIAN        <= ctrl_reg[`DCC_BIT_BIG];
			TRANSFER_REQUEST  <= req_pulse;
			IRQ               <= |(status_next & mask_reg);
		end
	end

endmodule // dcc_channel_ctrl

// >>> common/dcc_defs.vh
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// Register byte addresses
`define DCC_ADDR_CTRL        8'h00
`define DCC_ADDR_STATUS      8'h04
`define DCC_ADDR_MASK        8'h08
`define DCC_ADDR_EVENT       8'h0c

// Channel control field positions
`define DCC_BIT_NIE          23
`define DCC_BIT_AIE          22
`define DCC_BIT_RSV21        21
`define DCC_BIT_BIG          17
`define DCC_BIT_EXR          14
`define DCC_BIT_POL          13
`define DCC_BIT_LEV          12

// Implemented bits of the control register and its reset value
`define DCC_CTRL_MASK        32'h00e7f000
`define DCC_CTRL_RESET       32'h00e20000

// Status and mask layout
`define DCC_ST_NORMAL        0
`define DCC_ST_ABNORMAL      1
`define DCC_ST_REQUEST       2
`define DCC_ST_WIDTH         3
`define DCC_MASK_RESET       3'h0

// AXI responses
`define DCC_RESP_OKAY        2'h0
`define DCC_RESP_SLVERR      2'h2

`endif

// >>> design/dcc_req_qual.v
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Qualifies the request line; emits a one-cycle pulse per new request in edge mode, a level held while active in level mode
module dcc_req_qual (
	input  wire clk,
	input  wire reset,
	input  wire source_ext,
	input  wire polarity,
	input  wire level_mode,
	input  wire line_in,
	output reg  req_active,
	output reg  req_pulse
);

	reg line_prev_reg;
	wire active_now;

	// Polarity counts only for external requests
	assign active_now = source_ext & (line_in ^ polarity);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			line_prev_reg <= 1'b0;
			req_active    <= 1'b0;
			req_pulse     <= 1'b0;
		end else begin
			line_prev_reg <= active_now;
			req_active    <= active_now;
			req_pulse     <= level_mode ? active_now : (active_now & ~line_prev_reg);
		end
	end

endmodule // dcc_req_qual

// >>> design/dcc_irq_gate.v
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Gates completion events with their enables
module dcc_irq_gate (
	input  wire clk,
	input  wire reset,
	input  wire normal_enable,
	input  wire abnormal_enable,
	input  wire normal_done,
	input  wire abnormal_done,
	output reg  normal_event,
	output reg  abnormal_event
);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			normal_event   <= 1'b0;
			abnormal_event <= 1'b0;
		end else begin
			normal_event   <= normal_done & normal_enable;
			abnormal_event <= abnormal_done & abnormal_enable;
		end
	end

endmodule // dcc_irq_gate

// >>> verif/dcc_channel_ctrl_sva.sv
`timescale 1ns/1ps
module dcc_channel_ctrl_sva (
	input logic        CLK,
	input logic        RESET,
	input logic [1:0]  S_AXI_BRESP,
	input logic        S_AXI_BVALID,
	input logic        S_AXI_BREADY,
	input logic [31:0] S_AXI_RDATA,
	input logic        S_AXI_RVALID,
	input logic        S_AXI_RREADY,
	input logic        NORMAL_DONE,
	input logic        ABNORMAL_DONE,
	input logic        NORMAL_DONE_IRQ,
	input logic        ABNORMAL_DONE_IRQ,
	input logic        BIG_ENDIAN,
	input logic        TRANSFER_REQUEST
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_nrm; NORMAL_DONE_IRQ |-> $past(NORMAL_DONE, 2); endproperty
	a_nrm: assert property (p_nrm) else $error("normal irq without event");
	property p_abn; ABNORMAL_DONE_IRQ |-> $past(ABNORMAL_DONE, 2); endproperty
	a_abn: assert property (p_abn) else $error("abnormal irq without event");
	property p_nrst; $fell(RESET) && NORMAL_DONE |-> ##2 NORMAL_DONE_IRQ; endproperty
	a_nrst: assert property (p_nrst) else $error("normal irq off after reset");
	property p_arst; $fell(RESET) && ABNORMAL_DONE |-> ##2 ABNORMAL_DONE_IRQ; endproperty
	a_arst: assert property (p_arst) else $error("abnormal irq off after reset");
	property p_big; $fell(RESET) |-> BIG_ENDIAN; endproperty
	a_big: assert property (p_big) else $error("endian not big after reset");
	property p_bigw; $changed(BIG_ENDIAN) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2); endproperty
	a_bigw: assert property (p_bigw) else $error("endian moved without write");
	property p_src; $fell(RESET) |-> !TRANSFER_REQUEST [*3]; endproperty
	a_src: assert property (p_src) else $error("request after reset");
	property p_bh; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
	a_bh: assert property (p_bh) else $error("write response dropped");
	property p_rh; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
	a_rh: assert property (p_rh) else $error("read response dropped");
	c_nrm: cover property (NORMAL_DONE_IRQ);
	c_abn: cover property (ABNORMAL_DONE_IRQ);
	c_req: cover property ($rose(TRANSFER_REQUEST));
endmodule // dcc_channel_ctrl_sva
bind dcc_channel_ctrl dcc_channel_ctrl_sva u_sva (.CLK, .RESET, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
	.S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .NORMAL_DONE, .ABNORMAL_DONE, .NORMAL_DONE_IRQ,
	.ABNORMAL_DONE_IRQ, .BIG_ENDIAN, .TRANSFER_REQUEST);

// >>> verif/dcc_src_model.sv
`timescale 1ns/1ps
// Request source and engine side, one register stage
module dcc_src_model (
	input  logic clk,
	input  logic line_cmd,
	input  logic n_cmd,
	input  logic a_cmd,
	output logic line = 1'b0,
	output logic normal_done = 1'b0,
	output logic abnormal_done = 1'b0
);
	always @(posedge clk) begin
		line <= line_cmd;
		normal_done <= n_cmd;
		abnormal_done <= a_cmd;
	end
endmodule // dcc_src_model

// >>> verif/dma_channel_control_fields_tb.sv
`timescale 1ns/1ps
module dma_channel_control_fields_tb;
	logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic        lc = 0, nc = 1, ac = 1, rl, nd, ad, awr, wrd, bv, arr, rv, nirq, airq, big, treq, irq;
	logic [1:0]  br, rr;
	logic [7:0]  aa = 0, ra = 0;
	logic [31:0] wd = 0, rd;
	logic [2:0]  cfg;
	logic [14:0] tab = 15'b100_111_101_010_000;
	integer      miscompares = 0, comparisons = 0, mctrl = 32'h00e20000, mmask = 0, mstat = 0, i, cnt;
	always #10 clk = ~clk;
	dcc_channel_ctrl dut (.CLK(clk), .RESET(rst), .S_AXI_AWADDR(aa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .CHANNEL_REQUEST_LINE(rl),
		.NORMAL_DONE(nd), .ABNORMAL_DONE(ad), .NORMAL_DONE_IRQ(nirq), .ABNORMAL_DONE_IRQ(airq),
		.BIG_ENDIAN(big), .TRANSFER_REQUEST(treq), .IRQ(irq));
	dcc_src_model src (.clk(clk), .line_cmd(lc), .n_cmd(nc), .a_cmd(ac), .line(rl), .normal_done(nd),
		.abnormal_done(ad));
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		aa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv);
		bry <= 1'b0;
		chk(br, (a > 8'h0c) ? 32'h2 : 32'h0);
		if (a == 8'h00) mctrl = d & 32'h00e7f000;
		if (a == 8'h08) mmask = d & 32'h7;
	endtask
	task axr(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		ra <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rry <= 1'b0;
		chk(rd, e);
		chk(rr, (a > 8'h0c) ? 32'h2 : 32'h0);
	endtask
	// Both completion events for one cycle, then the interrupt line is judged
	task ev;
		@(posedge clk);
		nc <= 1'b1;
		ac <= 1'b1;
		@(posedge clk);
		nc <= 1'b0;
		ac <= 1'b0;
		// Event reaches the pins two edges after the command drops and is sampled on the third
		repeat (3) @(posedge clk);
		chk(nirq, mctrl[23]);
		chk(airq, mctrl[22]);
		repeat (2) @(posedge clk);
		mstat = mstat | {mctrl[22], mctrl[23]};
		chk(irq, (mstat & mmask) != 0);
	endtask
	initial begin
		void'($urandom(80471));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		nc <= 1'b0;
		ac <= 1'b0;
		mstat = 3;
		chk(big, 32'h1);
		axr(8'h00, 32'h00e20000);
		axr(8'h04, mstat);
		mstat = 0;
		axw(8'h08, 32'h7);
		for (i = 0; i < 4; i++) begin
			axw(8'h00, {8'h0, i[0], i[1], 22'h0} | ($urandom & 32'h00023000));
			axr(8'h00, mctrl);
			repeat (2) @(posedge clk);
			chk(big, mctrl[17]);
			ev;
			axr(8'h04, mstat);
			mstat = 0;
		end
		axw(8'h08, 32'h0);
		ev;
		axr(8'h04, mstat);
		axw(8'h10, 32'h00c00000);
		axr(8'h10, 32'h0);
		axr(8'h00, mctrl);
		for (i = 0; i < 5; i++) begin
			cfg = tab[3*i +: 3];
			lc <= cfg[1];
			axw(8'h00, {17'h0, cfg, 12'h0});
			repeat (6) @(posedge clk);
			lc <= ~cfg[1];
			cnt = 0;
			repeat (8) begin
				@(posedge clk);
				cnt += treq;
			end
			chk(cfg[0] ? treq : cnt, cfg[2]);
		end
		give_verdict;
	end
	initial begin
		#200000;
		miscompares++;
		give_verdict;
	end
endmodule // dma_channel_control_fields_tb
